// >>> rtl/cpd_power_down_ctrl.sv
// Overview of operation
// - Power-down request is an asynchronous active-low input.
// - Request is synchronised into the local clock before use.
// - Qualified after sampled low on two consecutive complement CPU rises.
// - PCI, AGP and USB clocks stop at next falling edge, ref clock at the one after; all stay low.
// - CPU pairs park true high at double current, complement undriven.
// - Stopping is synchronous to each clock, no runts or glitches.
// - Reference clocks may take more than one cycle to stop.
// - VCO and PLLs are disabled while powered down.
// - Release starts power-up without waiting for any output edge.
// - All clocks run again under three milliseconds after release.
`timescale 1ns/10ps
`include "cpd_params.svh"
module cpd_power_down_ctrl #(
  parameter int unsigned PU_LIMIT =
    `CPD_PU_MAX_NS / `CPD_CLK_PERIOD_NS - `CPD_PU_MARGIN
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic power_down_request_n,
  input wire logic pll_locked,
  output logic [2:0] cpu_clock_true,
  output logic [2:0] cpu_clock_complement,
  output logic [2:0] cpu_comp_oe,
  output logic [2:0] cpu_true_park_2x,
  output logic ref_clk,
  output logic pci_clk,
  output logic agp_clk,
  output logic usb_clk,
  output logic vco_enable,
  output logic pll_enable,
  output logic clocks_running
);
  localparam cpd_pkg::cpd_pu_t PU_MAX = cpd_pkg::cpd_pu_t'(PU_LIMIT);
  localparam cpd_pkg::cpd_cnt_t HALF_TAB [4] = '{
    `CPD_REF_HALF, `CPD_PCI_HALF, `CPD_AGP_HALF, `CPD_USB_HALF};
  localparam cpd_pkg::cpd_cnt_t LAG_TAB [4] = '{
    `CPD_REF_LAG, `CPD_NO_LAG, `CPD_NO_LAG, `CPD_NO_LAG};

  // =====================================================
  // Input synchronisers
  logic req_s1_reg;
  logic req_s2_reg;
  logic lock_s1_reg;
  logic lock_s2_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req_s1_reg <= 1'b1;
      req_s2_reg <= 1'b1;
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end else begin
      req_s1_reg <= power_down_request_n;
      req_s2_reg <= req_s1_reg;
      lock_s1_reg <= pll_locked;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  // =====================================================
  // CPU pair generator and parking
  cpd_pkg::cpd_cnt_t cpu_cnt_reg;
  logic true_reg;
  logic comp_reg;
  logic park_reg;
  logic run_reg;
  wire cpu_tick = (cpu_cnt_reg == 8'h00);
  wire comp_rise = cpu_tick && true_reg && !park_reg;
  wire park_now = cpu_tick && !true_reg && !park_reg && !run_reg;
  wire unpark_now = cpu_tick && park_reg && run_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_cnt_reg <= 8'h00;
    end else begin
      cpu_cnt_reg <= cpu_tick ? `CPD_CPU_HALF - 8'h01 : cpu_cnt_reg - 8'h01;
    end
  end

  // Parks on a rising true edge, so the last high phase is not cut
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      true_reg <= 1'b0;
      comp_reg <= 1'b1;
      park_reg <= 1'b0;
    end else if (park_now) begin
      true_reg <= 1'b1;
      comp_reg <= 1'b0;
      park_reg <= 1'b1;
    end else if (unpark_now) begin
      true_reg <= 1'b0;
      comp_reg <= 1'b1;
      park_reg <= 1'b0;
    end else if (cpu_tick && !park_reg) begin
      true_reg <= !true_reg;
      comp_reg <= true_reg;
    end
  end

  assign cpu_clock_true = {3{true_reg}};
  assign cpu_clock_complement = {3{comp_reg}};
  assign cpu_comp_oe = {3{!park_reg}};
  assign cpu_true_park_2x = {3{park_reg}};

  // =====================================================
  // Qualification on complement rising edges
  cpd_pkg::cpd_cnt_t qual_cnt_reg;
  wire qual_hit = comp_rise && !req_s2_reg &&
    (qual_cnt_reg == `CPD_QUAL_EDGES - 8'h01);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      qual_cnt_reg <= 8'h00;
    end else if (req_s2_reg || !run_reg) begin
      qual_cnt_reg <= 8'h00;
    end else if (comp_rise && !qual_hit) begin
      qual_cnt_reg <= qual_cnt_reg + 8'h01;
    end
  end

  // =====================================================
  // Non-CPU clock gates
  cpd_out_if gate_if [4] ();
  logic [3:0] stopped_w;
  logic [3:0] clk_w;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_gate
      assign gate_if[i].run = run_reg;
      assign stopped_w[i] = gate_if[i].stopped;
      assign clk_w[i] = gate_if[i].clk_out;
      cpd_clock_gate #(
        .HALF(HALF_TAB[i]),
        .LAG(LAG_TAB[i])
      ) u_gate (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .port_if(gate_if[i])
      );
    end
  endgenerate

  assign ref_clk = clk_w[0];
  assign pci_clk = clk_w[1];
  assign agp_clk = clk_w[2];
  assign usb_clk = clk_w[3];

  // =====================================================
  // Power sequencing
  cpd_pkg::cpd_state_e state_reg;
  cpd_pkg::cpd_state_e state_next;
  cpd_pkg::cpd_pu_t pu_cnt_reg;
  logic vco_reg;
  logic running_reg;
  wire all_down = (&stopped_w) && park_reg;
  wire pu_done = lock_s2_reg || (pu_cnt_reg >= PU_MAX);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cpd_pkg::ST_RUN: if (qual_hit) state_next = cpd_pkg::ST_STOP;
      cpd_pkg::ST_STOP: begin
        if (req_s2_reg) begin
          state_next = cpd_pkg::ST_LOCK;
        end else if (all_down) begin
          state_next = cpd_pkg::ST_OFF;
        end
      end
      cpd_pkg::ST_OFF: if (req_s2_reg) state_next = cpd_pkg::ST_LOCK;
      cpd_pkg::ST_LOCK: if (pu_done) state_next = cpd_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= cpd_pkg::ST_RUN;
      run_reg <= 1'b1;
      vco_reg <= 1'b1;
      running_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      run_reg <= (state_next == cpd_pkg::ST_RUN);
      vco_reg <= (state_next != cpd_pkg::ST_OFF);
      running_reg <= (state_next == cpd_pkg::ST_RUN);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pu_cnt_reg <= '0;
    end else if (state_reg != cpd_pkg::ST_LOCK) begin
      pu_cnt_reg <= '0;
    end else if (!pu_done) begin
      pu_cnt_reg <= pu_cnt_reg + 19'h0_0001;
    end
  end

  assign vco_enable = vco_reg;
  assign pll_enable = vco_reg;
  assign clocks_running = running_reg;

  // =====================================================
  // Checks
  a_qual_two_rises: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == cpd_pkg::ST_RUN && state_next == cpd_pkg::ST_STOP) |->
    (comp_rise && !req_s2_reg && !$past(req_s2_reg) &&
    qual_cnt_reg == 8'h01)) else $error("unqualified stop");
  a_sync_path: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(qual_cnt_reg == 8'h01) |-> !$past(req_s1_reg, 2))
    else $error("request used unsynchronised");
  a_park_pins: assert property (@(posedge sys_clk) disable iff (!rstn)
    park_reg |-> (&cpu_clock_true && !(|cpu_comp_oe) &&
    &cpu_true_park_2x)) else $error("bad cpu park");
  a_pll_off: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_reg == cpd_pkg::ST_OFF |-> (!vco_enable && !pll_enable &&
    &stopped_w)) else $error("pll on while down");
  a_release_fast: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == cpd_pkg::ST_OFF && req_s2_reg) |=>
    (state_reg == cpd_pkg::ST_LOCK && vco_enable))
    else $error("release delayed");
  a_pu_bound: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_reg == cpd_pkg::ST_LOCK |-> pu_cnt_reg <= PU_MAX)
    else $error("power-up too slow");
  a_lock_first: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(run_reg) |-> $past(lock_s2_reg) || $past(pu_cnt_reg) >= PU_MAX)
    else $error("run before lock");
  a_cpu_clean: assert property (@(posedge sys_clk) disable iff (!rstn)
    $changed(true_reg) |-> $past(cpu_tick)) else $error("cpu glitch");
  c_power_down: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_reg == cpd_pkg::ST_OFF);
  c_power_up: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_reg == cpd_pkg::ST_LOCK ##1 state_reg == cpd_pkg::ST_RUN);
  c_abort_stop: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_reg == cpd_pkg::ST_STOP ##1 state_reg == cpd_pkg::ST_LOCK);
endmodule : cpd_power_down_ctrl

// >>> rtl/cpd_params.svh
`ifndef CPD_PARAMS_SVH
`define CPD_PARAMS_SVH
// =====================================================
// Timing
`define CPD_CLK_PERIOD_NS 10
`define CPD_PU_MAX_NS 3000000
`define CPD_PU_MARGIN 1000
`define CPD_QUAL_EDGES 8'h02
// =====================================================
// Half periods in sys_clk cycles, reset values
`define CPD_CPU_HALF 8'h02
`define CPD_REF_HALF 8'h07
`define CPD_PCI_HALF 8'h06
`define CPD_AGP_HALF 8'h03
`define CPD_USB_HALF 8'h04
`define CPD_REF_LAG 8'h01
`define CPD_NO_LAG 8'h00
`define CPD_OUT_RST 1'b0
`endif

// >>> rtl/cpd_pkg.sv
package cpd_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_OFF, ST_LOCK} cpd_state_e;
  typedef logic [7:0] cpd_cnt_t;
  typedef logic [18:0] cpd_pu_t;
endpackage : cpd_pkg

// >>> rtl/cpd_out_if.sv
`timescale 1ns/10ps
interface cpd_out_if;
  logic run;
  logic clk_out;
  logic stopped;
  modport gate (input run, output clk_out, output stopped);
  modport ctrl (output run, input clk_out, input stopped);
endinterface : cpd_out_if

// >>> rtl/cpd_clock_gate.sv
`timescale 1ns/10ps
`include "cpd_params.svh"
module cpd_clock_gate #(
  parameter cpd_pkg::cpd_cnt_t HALF = `CPD_PCI_HALF,
  parameter cpd_pkg::cpd_cnt_t LAG = `CPD_NO_LAG
) (
  input wire logic sys_clk,
  input wire logic rstn,
  cpd_out_if.gate port_if
);
  cpd_pkg::cpd_cnt_t cnt_reg;
  cpd_pkg::cpd_cnt_t lag_reg;
  logic out_reg;
  logic stopped_reg;
  wire tick = (cnt_reg == 8'h00);
  wire hold = !port_if.run && (lag_reg == 8'h00);

  assign port_if.clk_out = out_reg;
  assign port_if.stopped = stopped_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= tick ? HALF - 8'h01 : cnt_reg - 8'h01;
    end
  end

  // =====================================================
  // Edges only on divider ticks, so no phase is cut short
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_reg <= `CPD_OUT_RST;
      stopped_reg <= 1'b0;
      lag_reg <= LAG;
    end else if (port_if.run && !out_reg) begin
      lag_reg <= LAG;
      if (tick) begin
        stopped_reg <= 1'b0;
        out_reg <= 1'b1;
      end
    end else if (tick) begin
      if (out_reg) begin
        out_reg <= 1'b0;
        if (hold) begin
          stopped_reg <= 1'b1;
        end else if (!port_if.run) begin
          lag_reg <= lag_reg - 8'h01;
        end
      end else if (!stopped_reg) begin
        out_reg <= 1'b1;
      end
    end
  end

  a_low_when_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
    stopped_reg |-> !out_reg) else $error("stopped clock not low");
  a_stop_on_fall: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(stopped_reg) |-> $fell(out_reg)) else $error("stop not at fall");
  a_edge_on_tick: assert property (@(posedge sys_clk) disable iff (!rstn)
    $changed(out_reg) |-> $past(tick)) else $error("runt edge");
  a_restart_high: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(stopped_reg) |-> $rose(out_reg)) else $error("bad restart");
  c_gate_stop: cover property (@(posedge sys_clk) disable iff (!rstn)
    $rose(stopped_reg));
endmodule : cpd_clock_gate

// >>> tb/cpd_pm_model.sv
`timescale 1ns/10ps
module cpd_pm_model #(
  parameter int LOCK_DLY = 8
) (
  input wire logic sys_clk,
  input wire logic want_down,
  input wire logic lock_ok,
  input wire logic pll_enable,
  output logic power_down_request_n,
  output logic pll_locked
);
  int lock_cnt;
  initial begin
    power_down_request_n = 1'b1;
    pll_locked = 1'b0;
    lock_cnt = 0;
  end
  // ==========================================
  // Request first; supply is never cut here
  always @(negedge sys_clk) begin
    power_down_request_n <= ~want_down;
  end
  // ==========================================
  // Lock needs an enabled PLL; lock_ok low models a PLL that never locks
  always @(negedge sys_clk) begin
    if (!pll_enable || !lock_ok) begin
      lock_cnt <= 0;
      pll_locked <= 1'b0;
    end else if (lock_cnt < LOCK_DLY) begin
      lock_cnt <= lock_cnt + 1;
    end else begin
      pll_locked <= 1'b1;
    end
  end
endmodule : cpd_pm_model

// >>> tb/cpd_power_down_ctrl_tb.sv
`timescale 1ns/10ps
`include "cpd_params.svh"
module cpd_power_down_ctrl_tb;
  logic sys_clk, rstn, want_down, lock_ok, pdn, locked;
  logic [2:0] ct, cc, coe, park;
  logic ref_clk, pci_clk, agp_clk, usb_clk, vco_en, pll_en, running;
  int failures, n_tests, cyc, n;
  cpd_power_down_ctrl #(.PU_LIMIT(50)) uut (.sys_clk(sys_clk), .rstn(rstn),
    .power_down_request_n(pdn), .pll_locked(locked),
    .cpu_clock_true(ct), .cpu_clock_complement(cc), .cpu_comp_oe(coe),
    .cpu_true_park_2x(park), .ref_clk(ref_clk), .pci_clk(pci_clk),
    .agp_clk(agp_clk), .usb_clk(usb_clk), .vco_enable(vco_en),
    .pll_enable(pll_en), .clocks_running(running));
  cpd_pm_model #(.LOCK_DLY(8)) pm (.sys_clk(sys_clk), .want_down(want_down),
    .lock_ok(lock_ok), .pll_enable(pll_en), .power_down_request_n(pdn),
    .pll_locked(locked));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_on(input bit vco, input logic v, input int lim);
    n = 0;
    while (((vco ? vco_en : running) !== v) && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_on
  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("running", 8'h01, {7'h00, running});
    chk("vco pll", 8'h03, {6'h00, vco_en, pll_en});
    chk("cpu oe park", 8'h38, {2'h0, coe, park});
  endtask : t_reset
  task automatic t_short();
    logic seen;
    seen = 1'b0;
    want_down = 1'b1;
    repeat (3) @(negedge sys_clk);
    want_down = 1'b0;
    repeat (30) begin
      @(negedge sys_clk);
      seen |= ~running;
    end
    chk("single low sample", 8'h00, {7'h00, seen});
  endtask : t_short
  // Release while still stopping: straight back, PLLs never off
  task automatic t_abort();
    logic dropped;
    dropped = 1'b0;
    want_down = 1'b1;
    wait_on(1'b0, 1'b0, 20);
    want_down = 1'b0;
    n = 0;
    while (running !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      dropped |= ~vco_en;
      n++;
    end
    chk("abort keeps pll on", 8'h00, {7'h00, dropped});
    chk("abort restart", 8'h01, {7'h00, running});
  endtask : t_abort
  task automatic t_down();
    logic [7:0] snap, moved;
    want_down = 1'b1;
    wait_on(1'b0, 1'b0, 20);
    chk("qualify window", 8'h01, {7'h00, n >= 5 && n <= 16});
    wait_on(1'b1, 1'b0, 60);
    chk("vco off", 8'h00, {6'h00, vco_en, pll_en});
    chk("gated clocks", 8'h00,
        {4'h0, ref_clk, pci_clk, agp_clk, usb_clk});
    chk("cpu park", 8'h3f, {2'h0, ct, park});
    chk("cpu comp", 8'h00, {2'h0, cc, coe});
    snap = {ref_clk, pci_clk, agp_clk, usb_clk, ct[0], cc[0], vco_en, 1'b0};
    moved = 8'h00;
    repeat (40) begin
      @(negedge sys_clk);
      moved |= snap ^ {ref_clk, pci_clk, agp_clk, usb_clk, ct[0], cc[0],
                       vco_en, 1'b0};
    end
    chk("held stopped", 8'h00, moved);
  endtask : t_down
  task automatic t_up(input logic lk, input int lim);
    logic [4:0] hi;
    logic [4:0] lo;
    lock_ok = lk;
    want_down = 1'b0;
    wait_on(1'b1, 1'b1, 5);
    chk("vco on", 8'h01, {7'h00, n <= 4});
    wait_on(1'b0, 1'b1, 80);
    chk("restart latency", 8'h01, {7'h00, n <= lim});
    n = 0;
    while (pci_clk !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    while (pci_clk === 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk("first pci pulse", `CPD_PCI_HALF, n[7:0]);
    chk("cpu unparked", 8'h38, {2'h0, coe, park});
    hi = 5'h00;
    lo = 5'h00;
    repeat (30) begin
      @(negedge sys_clk);
      hi |= {ref_clk, pci_clk, agp_clk, usb_clk, ct[0]};
      lo |= ~{ref_clk, pci_clk, agp_clk, usb_clk, ct[0]};
    end
    chk("clocks toggling", 8'h1f, {3'h0, hi & lo});
    lock_ok = 1'b1;
  endtask : t_up
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    rstn = 1'b0;
    want_down = 1'b0;
    lock_ok = 1'b1;
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_short();
    t_abort();
    t_down();
    t_up(1'b1, 20);
    t_down();
    t_up(1'b0, 60);
    finish_test();
  end
endmodule : cpd_power_down_ctrl_tb
